// File: shared/serdes_rx_pkg.sv
/*
  Shared constants and carrier types for the receive, loopback and
  transmit-timing control block and its leaf modules.
  Assumes one bit-rate clock domain; all pins are sampled as synchronous.
*/
package serdes_rx_pkg;

  // ----------------------------------------------------------------
  // Clock and word geometry
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int WORD_BITS = 16;
  // Bits per reference clock period: the reference runs at word rate
  localparam int REF_BITS_PER_PERIOD = 16;
  // Tolerance of the frequency window, in bits per reference period
  localparam int FREQ_TOL_BITS = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Transmit holding logic idles on a 1010 pattern while reset
  localparam logic [WORD_BITS-1:0] TX_IDLE_PATTERN = 16'haaaa;
  localparam logic [WORD_BITS-1:0] RX_WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic retimedLineLoopEn;
    logic equipmentLoopEn;
    logic rawLineLoopEn;
    logic recoveredClockTxEn;
  } mode_cfg_t;

  typedef enum logic [0:0] {
    CDR_TRACK_REF  = 1'b0,
    CDR_TRACK_DATA = 1'b1
  } cdr_state_t;

endpackage : serdes_rx_pkg

// File: src/bit_shifter.sv
/*
  Parameterised MSB-first shift register with parallel load.
  Assumes load and shift are qualified strobes of the caller's clock.
*/
`timescale 1ns/1ns
module bit_shifter #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk, // Bit-rate clock
  input wire logic rstN, // Asynchronous reset, active low
  input wire logic load, // Parallel load, wins over shift
  input wire logic [W-1:0] loadVal, // Word to load
  input wire logic shift, // Shift one place towards the MSB
  input wire logic inBit, // Bit entering at the LSB
  output logic [W-1:0] q // Register contents
);

  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (load) begin
      nxt_q = loadVal;
    end else if (shift) begin
      nxt_q = {q_ff[W-2:0], inBit};
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule : bit_shifter

// File: src/freq_monitor.sv
/*
  Counts incoming bit edges per reference period and judges whether the
  incoming stream lies inside the valid frequency window.
  Assumes refTick marks one reference period and bitTick one incoming bit.
*/
`timescale 1ns/1ns
module freq_monitor #(
  parameter int NOMINAL = 16,
  parameter int TOL = 1
) (
  input wire logic clk, // Bit-rate clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic bitTick, // One incoming bit edge
  input wire logic refTick, // One reference period boundary
  output logic inRange // Stream frequency within window
);

  localparam int CW = $clog2(2 * NOMINAL + 2) + 1;
  localparam logic [CW-1:0] MAXC = {CW{1'b1}};
  localparam logic [CW-1:0] LO = CW'(NOMINAL - TOL);
  localparam logic [CW-1:0] HI = CW'(NOMINAL + TOL);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic inRange_ff;
  logic nxt_inRange;
  logic [CW-1:0] total;

  always_comb begin
    // Saturate so a runaway stream never wraps back into the window
    total = (cnt_ff == MAXC) ? MAXC : cnt_ff + CW'(bitTick);
    nxt_cnt = total;
    nxt_inRange = inRange_ff;
    if (refTick) begin
      nxt_cnt = '0;
      nxt_inRange = (total >= LO) && (total <= HI);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      inRange_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      inRange_ff <= nxt_inRange;
    end
  end

  assign inRange = inRange_ff;

endmodule : freq_monitor

// File: src/serdes_receive_loopback_control.sv
/*
  Receive side control of a 16-bit serial transceiver: line fault flag,
  clock recovery source choice, MSB-first deserializer, loopback and
  loop-timing selection, reset and power-down handling.
  Assumes clk is the bit-rate clock, rxBitStrobe marks a recovered bit
  edge from the analog front end, and all inputs are synchronous to clk.
  // Function
  // RULE1: Fault flag rises at once, clears on reference.
  // RULE2: Out-of-range stream: recovery follows reference clock.
  // RULE3: In-range stream again: recovery follows data.
  // RULE4: Reference at word rate steers recovery.
  // RULE5: Reference within 100 ppm of far end.
  // RULE6: External switch after fault; device reacquires lock.
  // RULE7: First received bit lands in word MSB.
  // RULE8: Retimed line loop sends retimed input out.
  // RULE9: Retimed loop still deserializes and clocks words.
  // RULE10: Equipment loop feeds transmit bits into recovery.
  // RULE11: Equipment loop ignores signal detect.
  // RULE12: Raw line loop passes input unretimed.
  // RULE13: Loop timing clocks transmitter from recovered clock.
  // RULE14: Global reset clears all but transmit holding.
  // RULE15: Phase buffer reset clears transmit holding logic.
  // RULE16: Power down puts block in idle state.
  // RULE17: Controller also asserts resets during power down.
  // RULE18: Raw loop else transmit shifter drives output.
  // RULE19: Otherwise transmit bit clock is reference times sixteen.
  // RULE20: New word and clock edge every sixteen bits.
  // RULE21: Mode inputs are static configuration.
*/
`timescale 1ns/1ns
module serdes_receive_loopback_control import serdes_rx_pkg::*; #(
  parameter int WORD_W = WORD_BITS,
  parameter int FREQ_TOL = FREQ_TOL_BITS
) (
  input wire logic clk, // Bit-rate clock, 20 MHz
  input wire logic nrst, // Global reset, active low
  input wire logic phaseBufferResetN, // Transmit holding reset, active low
  input wire logic powerDownN, // Power down, active low
  input wire logic ce, // Clock enable, freezes all state but the rxWordValid pulse when low
  input wire mode_cfg_t modeCfg, // Loopback and timing modes
  input wire logic referenceClock, // Word-rate reference, sampled
  input wire logic serialIn, // Received serial data
  input wire logic rxBitStrobe, // Recovered bit edge from front end
  input wire logic signalDetectIn, // Optical module signal detect
  input wire logic forceReferenceLock, // Low forces lock to reference
  input wire logic [WORD_W-1:0] txWord, // Next transmit word
  output logic txWordTake, // Pulse: txWord taken this cycle
  output logic serialOut, // Serial line output
  output logic [WORD_W-1:0] rxWord, // Deserialized word
  output logic rxWordClock, // Divided recovered clock
  output logic rxWordValid, // Pulse: new rxWord this cycle
  output logic lineFaultFlag, // Line fault, active high
  output logic trackingData // Recovery follows data
);

  localparam int CNT_W = $clog2(WORD_W);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_W - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(WORD_W / 2 - 1);

  // ----------------------------------------------------------------
  // Strobes and clock selection
  // ----------------------------------------------------------------
  logic runEn;
  logic refEdge;
  logic multStrobe;
  logic rxStrobe;
  logic txStrobe;
  logic monTick;
  logic inRange;
  logic sdEff;
  logic txBit;
  logic rxSrcBit;
  logic [WORD_W-1:0] txShiftQ;
  logic [WORD_W-1:0] rxShiftQ;

  logic refPrev_ff;
  logic nxt_refPrev;
  cdr_state_t cdrState_ff;
  cdr_state_t nxt_cdrState;

  // Power down behaves as a frozen clock: no strobe moves any state
  assign runEn = ce & powerDownN; // RULE16
  assign refEdge = referenceClock & ~refPrev_ff;
  // The multiplied reference yields one transmit bit per clk cycle
  assign multStrobe = runEn; // RULE19

  always_comb begin
    // Equipment loop uses the multiplier so loop timing cannot close a loop
    if (modeCfg.equipmentLoopEn) begin
      rxStrobe = multStrobe; // RULE10
    end else if (cdrState_ff == CDR_TRACK_DATA) begin
      rxStrobe = runEn & rxBitStrobe; // RULE3
    end else begin
      rxStrobe = multStrobe; // RULE2
    end
  end

  assign txStrobe = (modeCfg.recoveredClockTxEn && !modeCfg.equipmentLoopEn) ?
                    rxStrobe : multStrobe; // RULE13 RULE19
  assign monTick = modeCfg.equipmentLoopEn ? multStrobe : (runEn & rxBitStrobe);

  // Reference period judges the recovered frequency
  freq_monitor #(
    .NOMINAL(REF_BITS_PER_PERIOD),
    .TOL(FREQ_TOL)
  ) u_freq_monitor (
    .clk(clk),
    .nrst(nrst),
    .bitTick(monTick),
    .refTick(refEdge & runEn), // RULE4
    .inRange(inRange)
  );

  always_comb begin
    nxt_refPrev = refPrev_ff;
    nxt_cdrState = cdrState_ff;
    if (runEn) begin
      nxt_refPrev = referenceClock;
      // Mode and lock changes simply retarget the loop; data may glitch meanwhile
      if (inRange && forceReferenceLock) begin
        nxt_cdrState = CDR_TRACK_DATA; // RULE3 RULE21
      end else begin
        nxt_cdrState = CDR_TRACK_REF; // RULE2
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refPrev_ff <= 1'b0;
      cdrState_ff <= CDR_TRACK_REF; // RULE14
    end else begin
      refPrev_ff <= nxt_refPrev;
      cdrState_ff <= nxt_cdrState;
    end
  end

  assign trackingData = (cdrState_ff == CDR_TRACK_DATA);

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] txCnt_ff;
  logic [CNT_W-1:0] nxt_txCnt;

  always_comb begin
    nxt_txCnt = txCnt_ff;
    if (txStrobe) begin
      nxt_txCnt = txCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txCnt_ff <= '0;
    end else begin
      txCnt_ff <= nxt_txCnt;
    end
  end

  assign txWordTake = txStrobe && (txCnt_ff == CNT_LAST);

  // Holding logic answers only to its own reset, not the global one
  bit_shifter #(
    .W(WORD_W),
    .RST(TX_IDLE_PATTERN)
  ) u_tx_shifter (
    .clk(clk),
    .rstN(phaseBufferResetN), // RULE15
    .load(txWordTake),
    .loadVal(txWord),
    .shift(txStrobe),
    .inBit(1'b0),
    .q(txShiftQ)
  );

  assign txBit = txShiftQ[WORD_W-1];

  // ----------------------------------------------------------------
  // Receive path and deserializer
  // ----------------------------------------------------------------
  logic retimedBit_ff;
  logic nxt_retimedBit;
  logic [CNT_W-1:0] rxCnt_ff;
  logic [CNT_W-1:0] nxt_rxCnt;
  logic [WORD_W-1:0] rxWord_ff;
  logic [WORD_W-1:0] nxt_rxWord;
  logic rxWordClock_ff;
  logic nxt_rxWordClock;
  logic rxWordValid_ff;
  logic nxt_rxWordValid;

  assign rxSrcBit = modeCfg.equipmentLoopEn ? txBit : serialIn; // RULE10

  // Deserializer keeps running in every loop mode
  bit_shifter #(
    .W(WORD_W),
    .RST(RX_WORD_RST)
  ) u_rx_shifter (
    .clk(clk),
    .rstN(nrst),
    .load(1'b0),
    .loadVal(RX_WORD_RST),
    .shift(rxStrobe), // RULE9
    .inBit(rxSrcBit),
    .q(rxShiftQ)
  );

  always_comb begin
    nxt_retimedBit = retimedBit_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_rxWord = rxWord_ff;
    nxt_rxWordClock = rxWordClock_ff;
    nxt_rxWordValid = 1'b0;
    if (rxStrobe) begin
      nxt_retimedBit = rxSrcBit; // RULE8
      nxt_rxCnt = rxCnt_ff + 1'b1;
      if (rxCnt_ff == CNT_LAST) begin
        // Earliest bit has travelled up to the MSB
        nxt_rxWord = {rxShiftQ[WORD_W-2:0], rxSrcBit}; // RULE7
        nxt_rxWordClock = 1'b1; // RULE20
        nxt_rxWordValid = 1'b1;
      end else if (rxCnt_ff == CNT_HALF) begin
        nxt_rxWordClock = 1'b0; // RULE20
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      retimedBit_ff <= 1'b0;
      rxCnt_ff <= '0;
      rxWord_ff <= RX_WORD_RST;
      rxWordClock_ff <= 1'b0;
      rxWordValid_ff <= 1'b0;
    end else begin
      retimedBit_ff <= nxt_retimedBit;
      rxCnt_ff <= nxt_rxCnt;
      rxWord_ff <= nxt_rxWord;
      rxWordClock_ff <= nxt_rxWordClock;
      rxWordValid_ff <= nxt_rxWordValid;
    end
  end

  assign rxWord = rxWord_ff;
  assign rxWordClock = rxWordClock_ff;
  assign rxWordValid = rxWordValid_ff;

  // ----------------------------------------------------------------
  // Serial output selection
  // ----------------------------------------------------------------
  always_comb begin
    if (!powerDownN) begin
      serialOut = 1'b0; // RULE16
    end else if (modeCfg.retimedLineLoopEn) begin
      serialOut = retimedBit_ff; // RULE8
    end else if (modeCfg.rawLineLoopEn) begin
      // Unretimed by intent: input passes straight through
      serialOut = serialIn; // RULE12 RULE18
    end else begin
      serialOut = txBit; // RULE18
    end
  end

  // ----------------------------------------------------------------
  // Line fault flag
  // ----------------------------------------------------------------
  logic faultSync_ff;
  logic nxt_faultSync;

  assign sdEff = modeCfg.equipmentLoopEn | signalDetectIn; // RULE11

  always_comb begin
    nxt_faultSync = faultSync_ff;
    // A low input is captured at once while runEn is high, so its later rise cannot clear the
    // flag before the next reference edge
    if (runEn && (refEdge || !sdEff || !forceReferenceLock)) begin
      nxt_faultSync = !sdEff || !forceReferenceLock || !inRange; // RULE1
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultSync_ff <= 1'b1;
    end else begin
      faultSync_ff <= nxt_faultSync;
    end
  end

  // Falling inputs raise the flag without waiting for any clock edge
  assign lineFaultFlag = faultSync_ff | ~sdEff | ~forceReferenceLock; // RULE1

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic firstBit_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      firstBit_ff <= 1'b0;
    end else if (rxStrobe && rxCnt_ff == '0) begin
      firstBit_ff <= rxSrcBit;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence wordEnd;
    rxStrobe && (rxCnt_ff == CNT_LAST);
  endsequence

  sequence wordShown;
    rxWordValid && rxWordClock;
  endsequence

  chk_fault_immediate: assert property (!forceReferenceLock || !sdEff |-> lineFaultFlag) // RULE1
    else $error("fault flag not raised by a low input");
  chk_fault_clear_ref: assert property ($fell(lineFaultFlag) |-> $past(refEdge && runEn)) // RULE1
    else $error("fault flag cleared away from a reference edge");
  chk_cdr_ref_hold: assert property ((runEn && !inRange) |=> cdrState_ff == CDR_TRACK_REF) // RULE2
    else $error("recovery did not fall back to reference");
  chk_cdr_ref_strobe: assert property (!trackingData && !modeCfg.equipmentLoopEn |->
                                       rxStrobe == runEn) // RULE2
    else $error("reference tracking does not follow reference strobe");
  chk_cdr_resume: assert property ((runEn && inRange && forceReferenceLock) |=>
                                   trackingData) // RULE3
    else $error("recovery did not resume data tracking");
  chk_msb_first: assert property (rxWordValid |-> rxWord[WORD_W-1] == $past(firstBit_ff)) // RULE7
    else $error("first received bit not in word MSB");
  chk_retimed_out: assert property (powerDownN && modeCfg.retimedLineLoopEn |->
                                    serialOut == retimedBit_ff) // RULE8
    else $error("retimed loop output wrong");
  chk_word_cadence: assert property (wordEnd |=> wordShown) // RULE9 RULE20
    else $error("word not presented after sixteen bits");
  chk_word_clock_rise: assert property ($rose(rxWordClock) |-> $past(rxStrobe) &&
                                        rxWordValid) // RULE20
    else $error("word clock rose without a new word");
  chk_equip_feed: assert property (modeCfg.equipmentLoopEn && rxStrobe |=>
                                   retimedBit_ff == $past(txBit)) // RULE10
    else $error("equipment loop did not feed transmit bits");
  chk_sd_ignored: assert property (modeCfg.equipmentLoopEn && forceReferenceLock &&
                                   !faultSync_ff |-> !lineFaultFlag) // RULE11
    else $error("signal detect not ignored in equipment loop");
  chk_raw_out: assert property (powerDownN && !modeCfg.retimedLineLoopEn &&
                                modeCfg.rawLineLoopEn |-> serialOut == serialIn) // RULE12
    else $error("raw loop output wrong");
  chk_tx_default: assert property (powerDownN && !modeCfg.retimedLineLoopEn &&
                                   !modeCfg.rawLineLoopEn |-> serialOut == txBit) // RULE18
    else $error("transmit shifter not on the output");
  chk_loop_timing: assert property (modeCfg.recoveredClockTxEn && !modeCfg.equipmentLoopEn |->
                                    txStrobe == rxStrobe) // RULE13
    else $error("transmitter not clocked from recovered clock");
  chk_mult_clock: assert property (!modeCfg.recoveredClockTxEn |-> txStrobe == runEn) // RULE19
    else $error("transmit clock not from multiplier");
  chk_fifo_reset: assert property (!phaseBufferResetN |-> txShiftQ == TX_IDLE_PATTERN) // RULE15
    else $error("transmit holding not in reset");
  chk_power_down: assert property (!powerDownN |=> $stable(rxWord) && !serialOut &&
                                   $stable(cdrState_ff)) // RULE16
    else $error("state moved during power down");

endmodule : serdes_receive_loopback_control

// File: sim/optic_module_model.sv
/*
  Optical module model: streams queued words MSB first with a bit strobe.
  Assumes the bench fills wq and sets rate; outputs change at negedge.
*/
`timescale 1ns/1ns
module optic_module_model (
  input wire logic clk, // Bit clock
  input wire logic nrst, // Holds the stream at the first bit
  input wire logic [1:0] rate, // 0 full, 1 one gap in 16, 2 half rate
  output logic serialIn, // Line data
  output logic rxBitStrobe // Recovered bit edge
);
  logic [15:0] wq[$];
  logic [15:0] fill = 16'h0f0f;
  logic [15:0] cur;
  int idx = 0;
  int cyc = 0;

  initial begin
    serialIn = 1'b0;
    rxBitStrobe = 1'b0;
  end

  // A word leaves the queue only after all its bits were taken, so the
  // word boundary seen by the receiver cannot slip
  always @(negedge clk) begin
    if (!nrst) begin
      idx = 0;
    end else if (rxBitStrobe) begin
      idx = idx + 1;
      if (idx == 16) begin
        idx = 0;
        if (wq.size() > 0) begin
          void'(wq.pop_front());
        end else begin
          fill = ~fill;
        end
      end
    end
    cur = (wq.size() > 0) ? wq[0] : fill;
    cyc = cyc + 1;
    rxBitStrobe <= (rate == 2'h0) || (rate == 2'h1 && cyc % 16 != 0) ||
      (rate == 2'h2 && cyc % 2 == 0);
    serialIn <= cur[15 - idx];
  end
endmodule : optic_module_model

// File: sim/testbench.sv
/*
  Self-checking bench for the receive, loopback and loop-timing control.
  Assumes the optical module model beside it and a 20 MHz bit clock.
*/
`timescale 1ns/1ns
module testbench import serdes_rx_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic phaseBufferResetN = 1'b0;
  logic powerDownN = 1'b1;
  logic ce = 1'b1;
  logic referenceClock = 1'b0;
  logic signalDetectIn = 1'b1;
  logic forceReferenceLock = 1'b1;
  mode_cfg_t modeCfg = '0;
  logic [15:0] txWord = 16'h002b;
  logic [15:0] lf = 16'h002b;
  logic [1:0] rate = 2'h0;
  logic serialIn, rxBitStrobe, txWordTake, serialOut, rxWordValid, rxWordClock;
  logic lineFaultFlag, trackingData, prevIn;
  logic [15:0] rxWord, curTx;
  logic [15:0] rxExp[$];
  int num_errors = 0;
  int check_count = 0;
  int refCnt = 0;
  int txLeft = 0;
  int cyc = 0;
  int stb = 0;
  int wc = 0;
  int vcnt = 0;
  bit live = 1'b0;

  initial begin
    forever #25 clk = ~clk;
  end

  serdes_receive_loopback_control i_serdes_receive_loopback_control (
    .clk(clk), .nrst(nrst), .phaseBufferResetN(phaseBufferResetN),
    .powerDownN(powerDownN), .ce(ce), .modeCfg(modeCfg), .referenceClock(referenceClock),
    .serialIn(serialIn), .rxBitStrobe(rxBitStrobe), .signalDetectIn(signalDetectIn),
    .forceReferenceLock(forceReferenceLock), .txWord(txWord), .txWordTake(txWordTake),
    .serialOut(serialOut), .rxWord(rxWord), .rxWordClock(rxWordClock),
    .rxWordValid(rxWordValid), .lineFaultFlag(lineFaultFlag), .trackingData(trackingData));

  optic_module_model i_optic_module_model (
    .clk(clk), .nrst(nrst), .rate(rate), .serialIn(serialIn), .rxBitStrobe(rxBitStrobe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextRand

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Modes change only under reset, since a live change may garble data
  task automatic doReset(input mode_cfg_t m, input int n);
    int i;
    live = 1'b0;
    nrst <= 1'b0;
    phaseBufferResetN <= 1'b0;
    powerDownN <= 1'b1;
    ce <= 1'b1;
    rate <= 2'h0;
    forceReferenceLock <= 1'b1;
    modeCfg <= m;
    // Refill only once the model sees reset, so it cannot pop a new word
    @(negedge clk);
    rxExp.delete();
    i_optic_module_model.wq.delete();
    for (i = 0; i < n; i++) begin
      lf = nextRand(lf);
      i_optic_module_model.wq.push_back(lf);
      rxExp.push_back(lf);
    end
    if (m.equipmentLoopEn) rxExp.push_back(TX_IDLE_PATTERN);
    @(negedge clk);
    check(rxWord, RX_WORD_RST);
    check(16'({rxWordValid, rxWordClock, trackingData, lineFaultFlag}), 16'h0001);
    if (!m.retimedLineLoopEn && !m.rawLineLoopEn) check(16'(serialOut), 16'h0001);
    nrst <= 1'b1;
    phaseBufferResetN <= 1'b1;
    curTx = TX_IDLE_PATTERN;
    txLeft = 16;
    cyc = 0;
    stb = 0;
    wc = 0;
    live = 1'b1;
  endtask : doReset

  task automatic waitTrack(input logic want);
    int i;
    for (i = 0; i < 200 && trackingData !== want; i++) @(negedge clk);
  endtask : waitTrack

  // ----------------------------------------------------------------
  // Reference clock and transmit words, driven at the falling edge
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    refCnt <= (refCnt + 1) % 16;
    referenceClock <= (refCnt < 8);
    txWord <= nextRand(txWord);
  end

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (nrst && rxWordValid) vcnt++;
    if (nrst && live) begin
      cyc++;
      stb += rxBitStrobe;
      if (rxWordValid) begin
        check(16'(rxWordClock), 16'h0001);
        if (rxExp.size() > 0) check(rxWord, rxExp.pop_front());
        wc = 8;
      end else if (wc > 0) begin
        wc--;
        if (wc == 0 && rate == 2'h0) check(16'(rxWordClock), 16'h0000);
      end
      if (!modeCfg.retimedLineLoopEn && !modeCfg.rawLineLoopEn && txLeft > 0) begin
        txLeft--;
        check(16'(serialOut), 16'(curTx[txLeft]));
      end
      if (modeCfg.retimedLineLoopEn && cyc > 1) check(16'(serialOut), 16'(prevIn));
      if (modeCfg.rawLineLoopEn) check(16'(serialOut), 16'(serialIn));
      if (txWordTake) begin
        if (modeCfg.recoveredClockTxEn) check(16'(stb), 16'h0010);
        else check(16'(cyc), 16'h0010);
        cyc = 0;
        stb = 0;
        curTx = txWord;
        txLeft = 16;
        if (modeCfg.equipmentLoopEn) rxExp.push_back(txWord);
      end
    end
    if (rxBitStrobe) prevIn = serialIn;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int v;
    @(negedge clk);
    doReset(mode_cfg_t'(4'h0), 40);
    repeat (200) @(negedge clk);
    check(16'({trackingData, lineFaultFlag}), 16'h0002);
    signalDetectIn <= 1'b0;
    #1 check(16'(lineFaultFlag), 16'h0001);
    @(negedge clk);
    signalDetectIn <= 1'b1;
    #1 check(16'(lineFaultFlag), 16'h0001);
    repeat (40) @(negedge clk);
    check(16'(lineFaultFlag), 16'h0000);
    forceReferenceLock <= 1'b0;
    #1 check(16'(lineFaultFlag), 16'h0001);
    repeat (2) @(negedge clk);
    check(16'(trackingData), 16'h0000);
    forceReferenceLock <= 1'b1;
    waitTrack(1'b1);
    check(16'(trackingData), 16'h0001);
    live = 1'b0;
    ce <= 1'b0;
    phaseBufferResetN <= 1'b0;
    #1 check(16'({trackingData, serialOut}), 16'h0003);
    @(negedge clk);
    v = vcnt;
    repeat (20) @(negedge clk);
    ce <= 1'b1;
    powerDownN <= 1'b0;
    #1 check(16'(serialOut), 16'h0000);
    repeat (20) @(negedge clk);
    check(16'(vcnt - v), 16'h0000);
    check(16'(trackingData), 16'h0001);
    nrst <= 1'b0;
    #1 check(16'(serialOut), 16'h0000);
    @(negedge clk);
    $display("test basic done");
    doReset(mode_cfg_t'(4'h4), 0);
    signalDetectIn <= 1'b0;
    repeat (160) @(negedge clk);
    check(16'(lineFaultFlag), 16'h0000);
    signalDetectIn <= 1'b1;
    $display("test equipment loop done");
    doReset(mode_cfg_t'(4'h9), 60);
    repeat (100) @(negedge clk);
    rate <= 2'h1;
    repeat (300) @(negedge clk);
    check(16'(trackingData), 16'h0001);
    live = 1'b0;
    rate <= 2'h2;
    waitTrack(1'b0);
    // The fault only sets at the next reference edge after the fallback
    repeat (20) @(negedge clk);
    check(16'({trackingData, lineFaultFlag}), 16'h0001);
    rate <= 2'h0;
    waitTrack(1'b1);
    check(16'(trackingData), 16'h0001);
    $display("test retimed loop timing done");
    doReset(mode_cfg_t'(4'h2), 20);
    repeat (100) @(negedge clk);
    $display("test raw loop done");
    conclude();
  end

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule : testbench
